// file: shared/iuc_pkg.sv
// Package with register map, field layout and constants of the instruction unit control block
package iuc_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CTL_LO = 4'h0;
    localparam logic [3:0] ADDR_CTL_HI = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
    // ------------------------------------------------------------
    // Field positions in the 64-bit register
    // ------------------------------------------------------------
    localparam int BASE_MSB = 47;
    localparam int BASE_LSB = 30;
    localparam int BASE_W = 18;
    localparam int REV_LSB = 24;
    localparam int REV_W = 6;
    localparam int BIST_BIT = 23;
    localparam int FILL_ORD_BIT = 22;
    localparam int MCHK_BIT = 21;
    localparam int LINK_SEL_BIT = 20;
    localparam int PC1_BIT = 19;
    localparam int PC0_BIT = 18;
    localparam int SINGLE_BIT = 17;
    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [BASE_W-1:0] BASE_RESET = 18'h00000;
    localparam logic [4:0] LINK_REG_SHADOW = 5'h17;
    localparam logic [4:0] LINK_REG_NORMAL = 5'h1B;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam int IRQ_W = 2;
    localparam int IRQ_WRITE = 0;
    localparam int IRQ_MCHK_DROP = 1;
endpackage : iuc_pkg

// file: logic/iuc_top.sv
// Instruction unit control register with classic Wishbone slave and interrupt
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module iuc_top #(
    parameter logic [5:0] REVISION_ID = 6'h2A // Arbitrary value
)(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic self_test_failed_i,
    input wire logic system_counting_enable_i,
    input wire logic process_counting_enable_i,
    input wire logic machine_check_req_i,
    output logic fill_flow_ordering_enable_o,
    output logic machine_check_take_o,
    output logic [4:0] call_link_register_o,
    output logic perf_counter1_count_o,
    output logic perf_counter0_count_o,
    output logic single_issue_o,
    output logic [63:0] page_table_base_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [iuc_pkg::BASE_W-1:0] base;
        logic fill_ord;
        logic machine_check_enable;
        logic link_sel;
        logic pc1_en;
        logic pc0_en;
        logic single;
        logic [1:0] st_sync;
        logic [1:0] sys_sync;
        logic [1:0] proc_sync;
        logic [1:0] mchk_sync;
        logic [iuc_pkg::IRQ_W-1:0] irq_status;
        logic [iuc_pkg::IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic ack;
        logic fill_o;
        logic mchk_o;
        logic [4:0] link_o;
        logic pc1_o;
        logic pc0_o;
        logic single_o;
        logic [63:0] base_o;
        logic irq;
    } iuc_state_t;

    iuc_state_t s;
    iuc_state_t next_s;

    // Byte-lane merge of write data into a 32-bit word
    function automatic logic [31:0] iuc_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[8*i +: 8] = wd[8*i +: 8];
        end
        return r;
    endfunction : iuc_merge

    // Full 64-bit register image
    function automatic logic [63:0] iuc_image(input iuc_state_t x, input logic bist);
        logic [63:0] v;
        v = 64'h0000000000000000;
        v[iuc_pkg::BASE_MSB:iuc_pkg::BASE_LSB] = x.base;
        v[63:48] = {16{x.base[iuc_pkg::BASE_W-1]}};
        v[iuc_pkg::REV_LSB +: iuc_pkg::REV_W] = REVISION_ID;
        v[iuc_pkg::BIST_BIT] = bist;
        v[iuc_pkg::FILL_ORD_BIT] = x.fill_ord;
        v[iuc_pkg::MCHK_BIT] = x.machine_check_enable;
        v[iuc_pkg::LINK_SEL_BIT] = x.link_sel;
        v[iuc_pkg::PC1_BIT] = x.pc1_en;
        v[iuc_pkg::PC0_BIT] = x.pc0_en;
        v[iuc_pkg::SINGLE_BIT] = x.single;
        return v;
    endfunction : iuc_image

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [63:0] img;
        logic [63:0] wimg;
        logic req;
        logic wr;
        logic [iuc_pkg::IRQ_W-1:0] ev;
        logic [iuc_pkg::IRQ_W-1:0] clr;
        img = 64'h0000000000000000;
        wimg = 64'h0000000000000000;
        req = 1'b0;
        wr = 1'b0;
        ev = 2'h0;
        clr = 2'h0;
        next_s = s;
        next_s.st_sync = {s.st_sync[0], self_test_failed_i};
        next_s.sys_sync = {s.sys_sync[0], system_counting_enable_i};
        next_s.proc_sync = {s.proc_sync[0], process_counting_enable_i};
        next_s.mchk_sync = {s.mchk_sync[0], machine_check_req_i};
        img = iuc_image(s, s.st_sync[1]);
        wimg = img;
        req = cyc_i && stb_i && !s.ack;
        wr = req && we_i;
        next_s.ack = req;
        next_s.rdata = 32'h00000000;
        if (req && !we_i)
        begin
            if (adr_i == iuc_pkg::ADDR_CTL_LO)
                next_s.rdata = img[31:0];
            else if (adr_i == iuc_pkg::ADDR_CTL_HI)
                next_s.rdata = img[63:32];
            else if (adr_i == iuc_pkg::ADDR_IRQ_STATUS)
                next_s.rdata = {30'h00000000, s.irq_status};
            else if (adr_i == iuc_pkg::ADDR_IRQ_MASK)
                next_s.rdata = {30'h00000000, s.irq_mask};
            else
                next_s.rdata = 32'h00000000;
        end
        if (wr)
        begin
            if (adr_i == iuc_pkg::ADDR_CTL_LO)
                wimg[31:0] = iuc_merge(img[31:0], dat_i, sel_i);
            else if (adr_i == iuc_pkg::ADDR_CTL_HI)
                wimg[63:32] = iuc_merge(img[63:32], dat_i, sel_i);
            else if (adr_i == iuc_pkg::ADDR_IRQ_STATUS && sel_i[0])
                clr = dat_i[iuc_pkg::IRQ_W-1:0];
            else if (adr_i == iuc_pkg::ADDR_IRQ_MASK && sel_i[0])
                next_s.irq_mask = dat_i[iuc_pkg::IRQ_W-1:0];
            // Only read-write fields are taken; identifier and flag are regenerated
            next_s.base = wimg[iuc_pkg::BASE_MSB:iuc_pkg::BASE_LSB];
            next_s.fill_ord = wimg[iuc_pkg::FILL_ORD_BIT];
            next_s.machine_check_enable = wimg[iuc_pkg::MCHK_BIT];
            next_s.link_sel = wimg[iuc_pkg::LINK_SEL_BIT];
            next_s.pc1_en = wimg[iuc_pkg::PC1_BIT];
            next_s.pc0_en = wimg[iuc_pkg::PC0_BIT];
            next_s.single = wimg[iuc_pkg::SINGLE_BIT];
        end
        // Events: any control write, and a machine check dropped while disabled
        ev[iuc_pkg::IRQ_WRITE] = wr && (adr_i == iuc_pkg::ADDR_CTL_LO
                                        || adr_i == iuc_pkg::ADDR_CTL_HI);
        ev[iuc_pkg::IRQ_MCHK_DROP] = s.mchk_sync[1] && !s.machine_check_enable;
        next_s.irq_status = (s.irq_status & ~clr) | ev;
        next_s.fill_o = s.fill_ord;
        next_s.mchk_o = s.mchk_sync[1] && s.machine_check_enable;
        next_s.link_o = s.link_sel ? iuc_pkg::LINK_REG_SHADOW : iuc_pkg::LINK_REG_NORMAL;
        next_s.pc1_o = s.pc1_en && (s.sys_sync[1] || s.proc_sync[1]);
        next_s.pc0_o = s.pc0_en && (s.sys_sync[1] || s.proc_sync[1]);
        next_s.single_o = s.single;
        next_s.base_o = {{16{s.base[iuc_pkg::BASE_W-1]}}, s.base, 30'h00000000};
        next_s.irq = |(s.irq_status & s.irq_mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= '0;
            s.base <= iuc_pkg::BASE_RESET;
            s.irq_status <= iuc_pkg::IRQ_RESET;
            s.irq_mask <= iuc_pkg::IRQ_RESET;
            s.link_o <= iuc_pkg::LINK_REG_NORMAL;
        end
        else
            s <= next_s;
    end

    assign dat_o = s.rdata;
    assign ack_o = s.ack;
    assign fill_flow_ordering_enable_o = s.fill_o;
    assign machine_check_take_o = s.mchk_o;
    assign call_link_register_o = s.link_o;
    assign perf_counter1_count_o = s.pc1_o;
    assign perf_counter0_count_o = s.pc0_o;
    assign single_issue_o = s.single_o;
    assign page_table_base_o = s.base_o;
    assign irq_o = s.irq;
endmodule : iuc_top
`default_nettype wire

// file: testbench/iuc_sva.sv
// Assertion checker for the instruction unit control register
`timescale 1ns/1ps
`default_nettype none
module iuc_sva #(parameter logic [5:0] REVISION_ID = 6'h2A)(
    input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o,
    input wire logic [3:0] adr_i, sel_i,
    input wire logic [31:0] dat_i, dat_o,
    input wire logic self_test_failed_i, system_counting_enable_i,
    input wire logic process_counting_enable_i, machine_check_req_i, machine_check_take_o,
    input wire logic fill_flow_ordering_enable_o, single_issue_o,
    input wire logic perf_counter1_count_o, perf_counter0_count_o,
    input wire logic [4:0] call_link_register_o,
    input wire logic [63:0] page_table_base_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wr_lo;
    // Write to the low word that touches the enable byte
    assign wr_lo = cyc_i && stb_i && we_i && !ack_o && adr_i == 4'h0 && sel_i[2];
    chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    chk_ack_delay: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing one cycle after request");
    chk_read_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not zero");
    chk_reset_state: assert property ($fell(rst_i) |-> call_link_register_o == 5'h1B
        && !fill_flow_ordering_enable_o && !single_issue_o && page_table_base_o == 64'h0)
        else $error("outputs not cleared by reset");
    chk_base_sext: assert property (page_table_base_o[63:48] == {16{page_table_base_o[47]}}
        && page_table_base_o[29:0] == 30'h0) else $error("base not sign extended");
    chk_rev_read: assert property (ack_o && !$past(we_i) && $past(adr_i) == 4'h0
        |-> dat_o[29:24] == REVISION_ID) else $error("revision field wrong");
    chk_fill_order: assert property (wr_lo |-> ##2 fill_flow_ordering_enable_o == $past(dat_i[22], 2))
        else $error("fill ordering output wrong");
    chk_link_select: assert property (wr_lo |-> ##2
        call_link_register_o == ($past(dat_i[20], 2) ? 5'h17 : 5'h1B)) else $error("link wrong");
    chk_single_issue: assert property (wr_lo |-> ##2 single_issue_o == $past(dat_i[17], 2))
        else $error("single issue output wrong");
    chk_count_idle: assert property ((!system_counting_enable_i && !process_counting_enable_i)[*4]
        |-> !perf_counter1_count_o && !perf_counter0_count_o) else $error("counter counts idle");
    chk_mchk_idle: assert property ((!machine_check_req_i)[*4] |-> !machine_check_take_o)
        else $error("machine check without request");
    cov_write: cover property (wr_lo);
    cov_irq: cover property (irq_o);
    cov_mchk: cover property (machine_check_take_o);
endmodule : iuc_sva
bind iuc_top iuc_sva #(.REVISION_ID(REVISION_ID)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o), .irq_o(irq_o), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .self_test_failed_i(self_test_failed_i),
    .system_counting_enable_i(system_counting_enable_i),
    .process_counting_enable_i(process_counting_enable_i),
    .machine_check_req_i(machine_check_req_i), .machine_check_take_o(machine_check_take_o),
    .fill_flow_ordering_enable_o(fill_flow_ordering_enable_o), .single_issue_o(single_issue_o),
    .perf_counter1_count_o(perf_counter1_count_o), .perf_counter0_count_o(perf_counter0_count_o),
    .call_link_register_o(call_link_register_o), .page_table_base_o(page_table_base_o));
`default_nettype wire

// file: testbench/iuc_top_tb.sv
// Self-checking bench for the instruction unit control register
`timescale 1ns/1ps
`default_nettype none
module iuc_top_tb;
    localparam logic [5:0] REV = 6'h15; // Arbitrary value
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic stf = 1'b0, sce = 1'b0, pce = 1'b0, mcr = 1'b0, ack, ffo, mct, pc1, pc0, sio, irq;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0, dout, rd;
    logic [4:0] clr;
    logic [63:0] ptb;
    int failures = 0, check_count = 0;
    always #50 clk_i = ~clk_i;
    iuc_top #(.REVISION_ID(REV)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dout), .ack_o(ack),
        .self_test_failed_i(stf), .system_counting_enable_i(sce), .process_counting_enable_i(pce),
        .machine_check_req_i(mcr), .fill_flow_ordering_enable_o(ffo), .machine_check_take_o(mct),
        .call_link_register_o(clr), .perf_counter1_count_o(pc1), .perf_counter0_count_o(pc0),
        .single_issue_o(sio), .page_table_base_o(ptb), .irq_o(irq));
    task automatic finish_test();
        $display("mismatches %0d checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // One classic bus cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        rd = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1)
        begin
            failures++;
            finish_test();
        end
    endtask : wb
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        wb(1'b0, a, 4'hF, 32'h0);
        cmp(rd, exp);
    endtask : rdc
    task automatic wt();
        repeat (5) @(posedge clk_i);
    endtask : wt
    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(4'h0, {2'h0, REV, 24'h0});
        rdc(4'h4, 32'h0);
        cmp({irq, mct, clr}, 7'h1B);
        wb(1'b1, 4'h0, 4'hF, 32'hFFFF_FFFF);
        wb(1'b1, 4'h4, 4'h3, 32'hFFFF_8000);
        wt();
        rdc(4'h0, {2'h3, REV, 1'b0, 6'h3F, 17'h0});
        rdc(4'h4, 32'hFFFF_8000);
        cmp(ptb, 64'hFFFF_8000_C000_0000);
        cmp(ffo, 1'b1);
        cmp(sio, 1'b1);
        cmp(clr, 5'h17);
        cmp({pc1, pc0}, 2'h0);
        sce <= 1'b1;
        wt();
        cmp({pc1, pc0}, 2'h3);
        wb(1'b1, 4'h0, 4'h4, 32'h0004_0000);
        sce <= 1'b0;
        pce <= 1'b1;
        stf <= 1'b1;
        wt();
        cmp({pc1, pc0, clr}, 7'h3B);
        rdc(4'h0, {2'h3, REV, 1'b1, 6'h02, 17'h0});
        wb(1'b1, 4'h8, 4'hF, 32'h3);
        mcr <= 1'b1;
        wt();
        cmp({mct, irq}, 2'h0);
        wb(1'b1, 4'hC, 4'hF, 32'h2);
        wt();
        cmp(irq, 1'b1);
        rdc(4'h8, 32'h2);
        wb(1'b1, 4'h0, 4'h4, 32'h0020_0000);
        wt();
        cmp(mct, 1'b1);
        mcr <= 1'b0;
        wb(1'b1, 4'h8, 4'hF, 32'h3);
        wt();
        cmp({mct, irq}, 2'h0);
        finish_test();
    end
endmodule : iuc_top_tb
`default_nettype wire
